// ### rtl/ipt_params.svh
/*
 * register map, field positions and reset values of the interrupt status
 * and proximity timer reload block; included by the top and the bench.
 */
`ifndef IPT_PARAMS_SVH
`define IPT_PARAMS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define IPT_OFF_STATUS 4'h0
`define IPT_OFF_RELOAD 4'h4
`define IPT_OFF_IRQSTAT 4'h8
`define IPT_OFF_IRQMASK 4'hC

// ----------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------
`define IPT_PRIO_LSB 8
`define IPT_PRIO_MSB 10
`define IPT_VEC_LSB 0
`define IPT_VEC_MSB 5
`define IPT_RELOAD_RST 32'h0000_0000
`define IPT_PRIO_RST 3'h0
`define IPT_VEC_RST 6'h00
`define IPT_IRQ_RST 2'h0
`define IPT_EV_TRIG 0
`define IPT_EV_PRES 1
`define IPT_RESP_OKAY 2'h0
`define IPT_RESP_SLVERR 2'h2

`endif

// ### rtl/ipt_pkg.sv
/*
 * types shared by the status and proximity timer reload block.
 * assumes ipt_params.svh is on the include path.
 */
package ipt_pkg;
    // state of the write channel of the register slave
    typedef enum logic [1:0] {
        IPT_WR_IDLE = 2'b00,
        IPT_WR_RESP = 2'b01
    } ipt_wr_state_t;
endpackage : ipt_pkg

// ### rtl/ipt_status_timer.sv
/*
 * interrupt status and proximity timer reload registers on an AXI4-Lite
 * slave. assumes the arbiter drives presPrio/presVec/presValid and the
 * timer pulses timerTrig on the clock clk, and accepts a one-cycle load.
 */
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
// Functional notes
// - report latest presented priority in bits 10:8
// - report presented vector number in bits 5:0
// - unimplemented status bits read as zero
// - 32-bit read/write proximity timer reload register
// - interrupt event loads timer from reload value
`timescale 1ns/1ps
`include "ipt_params.svh"

module ipt_status_timer
    import ipt_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [2:0] presPrio,
    input wire logic [5:0] presVec,
    input wire logic presValid,
    input wire logic timerTrig,
    output logic timerLoad,
    output logic [31:0] timerLoadValue,
    output logic irq
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [2:0] prio_r;
    logic [5:0] vec_r;
    logic [31:0] reload_r;
    logic [1:0] irqStat_r;
    logic [1:0] irqMask_r;
    logic awHeld_r, wHeld_r;
    logic [3:0] awAddr_r;
    logic [31:0] wData_r;
    logic [3:0] wStrb_r;
    ipt_wr_state_t wrState_r;

    // ------------------------------------------------------------------
    // write path decode
    // ------------------------------------------------------------------
    wire logic awTake = s_axi_awvalid && s_axi_awready;
    wire logic wTake = s_axi_wvalid && s_axi_wready;
    wire logic wrGo = awHeld_r && wHeld_r && (wrState_r == IPT_WR_IDLE);
    wire logic wrReload = wrGo && (awAddr_r == `IPT_OFF_RELOAD);
    wire logic wrIrqStat = wrGo && (awAddr_r == `IPT_OFF_IRQSTAT);
    wire logic wrIrqMask = wrGo && (awAddr_r == `IPT_OFF_IRQMASK);
    wire logic wrStatus = wrGo && (awAddr_r == `IPT_OFF_STATUS);
    wire logic wrBad = wrGo && !(wrReload || wrIrqStat || wrIrqMask || wrStatus);
    wire logic [1:0] events = {presValid, timerTrig};
    logic [31:0] reloadMerged;

    // byte-lane merge of the reload register
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign reloadMerged[gi*8 +: 8] = wStrb_r[gi] ? wData_r[gi*8 +: 8]
                                                         : reload_r[gi*8 +: 8];
        end
    endgenerate

    // address and data may arrive in either order; each is held until both are in
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            awAddr_r <= 4'h0;
            wData_r <= 32'h0000_0000;
            wStrb_r <= 4'h0;
        end else begin
            if (awTake) begin
                awHeld_r <= 1'b1;
                awAddr_r <= s_axi_awaddr[3:0];
            end else if (wrGo) begin
                awHeld_r <= 1'b0;
            end
            if (wTake) begin
                wHeld_r <= 1'b1;
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end else if (wrGo) begin
                wHeld_r <= 1'b0;
            end
        end
    end

    // each ready only while its own channel holds nothing and no response is pending, so one write at a time
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `IPT_RESP_OKAY;
            wrState_r <= IPT_WR_IDLE;
        end else begin
            s_axi_awready <= !awHeld_r && !awTake && (wrState_r == IPT_WR_IDLE);
            s_axi_wready <= !wHeld_r && !wTake && (wrState_r == IPT_WR_IDLE);
            if (wrGo) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrBad ? `IPT_RESP_SLVERR : `IPT_RESP_OKAY;
                wrState_r <= IPT_WR_RESP;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                wrState_r <= IPT_WR_IDLE;
            end
        end
    end

    // ------------------------------------------------------------------
    // status capture, reload register, timer load
    // ------------------------------------------------------------------
    // status is read-only here: the fields track the arbiter, not software
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prio_r <= `IPT_PRIO_RST;
            vec_r <= `IPT_VEC_RST;
            reload_r <= `IPT_RELOAD_RST;
            timerLoad <= 1'b0;
            timerLoadValue <= `IPT_RELOAD_RST;
        end else begin
            if (presValid) begin
                prio_r <= presPrio;
                vec_r <= presVec;
            end
            if (wrReload) begin
                reload_r <= reloadMerged;
            end
            timerLoad <= timerTrig;
            timerLoadValue <= reload_r;
        end
    end

    // ------------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------------
    // set wins over a write-one clear in the same cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irqStat_r <= `IPT_IRQ_RST;
            irqMask_r <= `IPT_IRQ_RST;
            irq <= 1'b0;
        end else begin
            irqStat_r <= (irqStat_r & ~(wrIrqStat ? wData_r[1:0] : 2'h0)) | events;
            if (wrIrqMask) begin
                irqMask_r <= wData_r[1:0];
            end
            irq <= |(irqStat_r & irqMask_r);
        end
    end

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    wire logic [3:0] rdOff = s_axi_araddr[3:0];
    wire logic rdHit = (rdOff == `IPT_OFF_STATUS) || (rdOff == `IPT_OFF_RELOAD) ||
                       (rdOff == `IPT_OFF_IRQSTAT) || (rdOff == `IPT_OFF_IRQMASK);
    wire logic [31:0] statusWord = {21'h0, prio_r, 2'h0, vec_r};
    wire logic [31:0] rdMux =
        (rdOff == `IPT_OFF_STATUS) ? statusWord :
        (rdOff == `IPT_OFF_RELOAD) ? reload_r :
        (rdOff == `IPT_OFF_IRQSTAT) ? {30'h0, irqStat_r} :
        (rdOff == `IPT_OFF_IRQMASK) ? {30'h0, irqMask_r} : 32'h0000_0000;

    // one read under way; arready drops while the answer stands
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `IPT_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdMux;
                s_axi_rresp <= rdHit ? `IPT_RESP_OKAY : `IPT_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end else begin
                s_axi_arready <= !s_axi_rvalid;
            end
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    AST_PRIO_TRACK: assert property (@(posedge clk) disable iff (!nrst)
        presValid |=> prio_r == $past(presPrio)) else $error("priority not captured");
    AST_VEC_TRACK: assert property (@(posedge clk) disable iff (!nrst)
        presValid |=> vec_r == $past(presVec)) else $error("vector not captured");
    AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (!nrst)
        (s_axi_arvalid && s_axi_arready && rdOff == `IPT_OFF_STATUS) |=>
        (s_axi_rdata[31:11] == 21'h0 && s_axi_rdata[7:6] == 2'h0))
        else $error("reserved status bits not zero");
    AST_RELOAD_WRITE: assert property (@(posedge clk) disable iff (!nrst)
        (wrReload && wStrb_r == 4'hF) |=> reload_r == $past(wData_r))
        else $error("reload write lost");
    AST_RELOAD_HOLD: assert property (@(posedge clk) disable iff (!nrst)
        !wrReload |=> $stable(reload_r)) else $error("reload changed without write");
    AST_TIMER_LOAD: assert property (@(posedge clk) disable iff (!nrst)
        timerTrig |=> (timerLoad && timerLoadValue == $past(reload_r)))
        else $error("timer not loaded from reload");
    AST_RESET_CLEAR: assert property (@(posedge clk)
        !nrst |-> (prio_r == 3'h0 && vec_r == 6'h00 && reload_r == 32'h0))
        else $error("reset did not clear fields");
    AST_IRQ_STICKY: assert property (@(posedge clk) disable iff (!nrst)
        (timerTrig && irqMask_r[0] && !wrIrqMask) |=> ##1 irq) else $error("irq not raised");
    AST_BRESP_ONE: assert property (@(posedge clk) disable iff (!nrst)
        wrGo |=> s_axi_bvalid) else $error("write not answered");

    COV_READ_STATUS: cover property (@(posedge clk) disable iff (!nrst)
        s_axi_rvalid && s_axi_rready && statusWord != 32'h0);
    COV_WRITE_RELOAD: cover property (@(posedge clk) disable iff (!nrst) wrReload);
    COV_TRIG_LOAD: cover property (@(posedge clk) disable iff (!nrst)
        timerLoad && timerLoadValue != 32'h0);
    COV_IRQ: cover property (@(posedge clk) disable iff (!nrst) irq);

endmodule : ipt_status_timer

// ### tb/ipt_far_model.sv
/* far-side model: the arbiter presenting priority/vector and the timer taking loads.
   assumes the bench calls present and trigger just after a rising edge of clk. */
`timescale 1ns/1ps
module ipt_far_model (
    input wire logic clk,
    input wire logic timerLoad,
    input wire logic [31:0] timerLoadValue,
    output logic [2:0] presPrio,
    output logic [5:0] presVec,
    output logic presValid,
    output logic timerTrig,
    output int loadCount,
    output logic [31:0] loadVal
);
    initial begin
        {presPrio, presVec, presValid, timerTrig} = 11'h0;
        loadCount = 0;
        loadVal = 32'h0;
    end
    // one-cycle event; fields inverted after so stale values never pass as valid
    task automatic present(input logic [2:0] p, input logic [5:0] v);
        presPrio <= p;
        presVec <= v;
        presValid <= 1'b1;
        @(posedge clk);
        presValid <= 1'b0;
        presPrio <= ~p;
        presVec <= ~v;
    endtask : present
    task automatic trigger();
        timerTrig <= 1'b1;
        @(posedge clk);
        timerTrig <= 1'b0;
    endtask : trigger
    // timer side takes every load pulse, counting them to catch doubles
    always @(posedge clk) begin
        if (timerLoad === 1'b1) begin
            loadCount <= loadCount + 1;
            loadVal <= timerLoadValue;
        end
    end
endmodule : ipt_far_model

// ### tb/irq_status_proximity_timer_tb.sv
/* self-checking bench: axi4-lite master, reference model, far-side model.
   assumes ipt_params.svh on the include path; 200 MHz clock. */
`timescale 1ns/1ps
`include "ipt_params.svh"
module irq_status_proximity_timer_tb;
    logic clk = 1'b0;
    logic nrst = 1'b1;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, seed = 32'h25;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, timerLoad, irq, presValid, timerTrig;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, timerLoadValue, loadVal, mReload, rv;
    logic [2:0] presPrio;
    logic [5:0] presVec;
    int n_fail = 0, tests_run = 0, loadCount, n0, mSt, mMask, mStat;
    ipt_status_timer dut (.clk(clk), .nrst(nrst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .presPrio(presPrio), .presVec(presVec), .presValid(presValid),
        .timerTrig(timerTrig), .timerLoad(timerLoad), .timerLoadValue(timerLoadValue),
        .irq(irq));
    ipt_far_model far (.clk(clk), .timerLoad(timerLoad), .timerLoadValue(timerLoadValue),
        .presPrio(presPrio), .presVec(presVec), .presValid(presValid),
        .timerTrig(timerTrig), .loadCount(loadCount), .loadVal(loadVal));
    initial begin
        forever #2.5 clk = ~clk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test
    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_word
    task automatic chk_bit(input string what, input logic exp, input logic got);
        chk_word(what, {31'h0, exp}, {31'h0, got});
    endtask : chk_bit
    task automatic hang();
        n_fail++;
        $display("ERROR handshake expected answer seen none");
        finish_test();
    endtask : hang
    // sampled at the falling edge: nothing moves there, so no race with the slave
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        logic aw, w, b;
        int n;
        @(posedge clk);
        awaddr <= {28'h0, a};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        b = 1'b0;
        n = 0;
        while (!b) begin
            @(negedge clk);
            aw = (awvalid & awready) === 1'b1;
            w = (wvalid & wready) === 1'b1;
            b = (bvalid & bready) === 1'b1;
            resp = bresp;
            if (++n > 200) hang();
            @(posedge clk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            if (b) bready <= 1'b0;
        end
        chk_word("bresp", 32'(`IPT_RESP_OKAY), {30'h0, resp});
    endtask : axi_wr
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        logic ar, r;
        int n;
        @(posedge clk);
        araddr <= {28'h0, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        r = 1'b0;
        n = 0;
        while (!r) begin
            @(negedge clk);
            ar = (arvalid & arready) === 1'b1;
            r = (rvalid & rready) === 1'b1;
            rv = rdata;
            resp = rresp;
            if (++n > 200) hang();
            @(posedge clk);
            if (ar) arvalid <= 1'b0;
            if (r) rready <= 1'b0;
        end
        chk_word("rresp", 32'(`IPT_RESP_OKAY), {30'h0, resp});
        chk_word($sformatf("read %h", a), exp, rv);
    endtask : rd_chk
    initial begin
        repeat (20000) @(posedge clk);
        hang();
    end
    initial begin
        static logic [3:0] opA [4] = '{`IPT_OFF_IRQMASK, `IPT_OFF_IRQSTAT, `IPT_OFF_IRQMASK,
            `IPT_OFF_IRQSTAT};
        static logic [31:0] opD [4] = '{32'h1, 32'h1, 32'h2, 32'h2};
        // a real falling edge at time zero, so the asynchronous reset acts before clock one
        nrst <= 1'b0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        mSt = 0;
        mMask = 0;
        rd_chk(`IPT_OFF_STATUS, 32'h0);
        rd_chk(`IPT_OFF_RELOAD, 32'h0);
        rd_chk(`IPT_OFF_IRQSTAT, 32'h0);
        rd_chk(`IPT_OFF_IRQMASK, 32'h0);
        $display("test reset values done");
        // reload round trip, then each trigger must load exactly once
        for (int i = 0; i < 4; i++) begin
            mReload = rnd();
            axi_wr(`IPT_OFF_RELOAD, mReload);
            rd_chk(`IPT_OFF_RELOAD, mReload);
            n0 = loadCount;
            far.trigger();
            mSt = mSt | 1;
            repeat (2) @(posedge clk);
            chk_word("load count", 32'(n0 + 1), 32'(loadCount));
            chk_word("load value", mReload, loadVal);
        end
        // partial strobe: only lanes 0 and 2 may change
        rv = rnd();
        mReload = (mReload & 32'hFF00_FF00) | (rv & 32'h00FF_00FF);
        wstrb <= 4'h5;
        axi_wr(`IPT_OFF_RELOAD, rv);
        wstrb <= 4'hF;
        rd_chk(`IPT_OFF_RELOAD, mReload);
        $display("test reload and trigger done");
        // every priority code; software reads as in single-vector use
        for (int p = 0; p < 8; p++) begin
            rv = rnd();
            mStat = p * 256 + int'(rv[5:0]);
            far.present(3'(p), rv[5:0]);
            mSt = mSt | 2;
            rd_chk(`IPT_OFF_STATUS, 32'(mStat));
        end
        axi_wr(`IPT_OFF_STATUS, 32'hFFFF_FFFF);
        rd_chk(`IPT_OFF_STATUS, 32'(mStat));
        $display("test status fields done");
        @(negedge clk);
        chk_bit("irq all masked", 1'b0, irq);
        rd_chk(`IPT_OFF_IRQSTAT, 32'(mSt));
        // unmask, clear, unmask other, clear: irq follows status and mask
        for (int k = 0; k < 4; k++) begin
            axi_wr(opA[k], opD[k]);
            if (opA[k] == `IPT_OFF_IRQMASK) mMask = int'(opD[k]);
            else mSt = mSt & ~int'(opD[k]);
            @(negedge clk);
            chk_bit("irq", (mSt & mMask) != 0, irq);
            rd_chk(`IPT_OFF_IRQSTAT, 32'(mSt));
        end
        // both sources unmasked: a fresh trigger must raise irq two edges later
        axi_wr(`IPT_OFF_IRQMASK, 32'h3);
        mMask = 3;
        n0 = loadCount;
        far.trigger();
        mSt = mSt | 1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk_bit("irq after trigger", (mSt & mMask) != 0, irq);
        chk_word("load count", 32'(n0 + 1), 32'(loadCount));
        rd_chk(`IPT_OFF_IRQSTAT, 32'(mSt));
        $display("test interrupt done");
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        rd_chk(`IPT_OFF_RELOAD, 32'h0);
        rd_chk(`IPT_OFF_STATUS, 32'h0);
        $display("test second reset done");
        finish_test();
    end
endmodule : irq_status_proximity_timer_tb
